// >>> hdl/prog_port_pkg.sv
package prog_port_pkg;

    // Load actions selected by the two action bits on a load strobe
    localparam logic [1:0] ACT_ADDR  = 2'b00;
    localparam logic [1:0] ACT_DATA  = 2'b01;
    localparam logic [1:0] ACT_CMD   = 2'b10;
    localparam logic [1:0] ACT_IDLE  = 2'b11;

    // Command byte coding
    localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
    localparam logic [7:0] CMD_WRITE_FUSE  = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK  = 8'h20;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_WRITE_EEP   = 8'h11;
    localparam logic [7:0] CMD_READ_SIG    = 8'h08;
    localparam logic [7:0] CMD_READ_FUSE   = 8'h04;
    localparam logic [7:0] CMD_READ_FLASH  = 8'h02;
    localparam logic [7:0] CMD_READ_EEP    = 8'h03;
    localparam logic [7:0] CMD_RESET       = 8'h00;

    // Lock byte: a bit reads 0 when programmed
    localparam int LOCK_BIT1_POS = 0;
    localparam int LOCK_BIT2_POS = 1;

    // Byte shown on the bus for a refused verification read
    localparam logic [7:0] REFUSED_READ_BYTE = 8'hff;

    localparam int WORD_FIFO_DEPTH = 4;
    localparam int WORD_FIFO_WIDTH = 24;

    typedef enum logic [2:0] {
        OP_NONE        = 3'b000,
        OP_CHIP_ERASE  = 3'b001,
        OP_WRITE_FUSE  = 3'b010,
        OP_WRITE_LOCK  = 3'b011,
        OP_WRITE_FLASH = 3'b100,
        OP_WRITE_EEP   = 3'b101
    } op_kind_t;

    typedef enum logic [2:0] {
        RD_NONE  = 3'b000,
        RD_SIG   = 3'b001,
        RD_FUSE  = 3'b010,
        RD_FLASH = 3'b011,
        RD_EEP   = 3'b100
    } read_kind_t;

endpackage : prog_port_pkg

// >>> hdl/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
    parameter int              WIDTH      = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb
    begin
        state_next        = state_reg;
        state_next.stage1 = pinIn;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_reg <= '{stage1: RESET_VALUE, stage2: RESET_VALUE};
        else
            state_reg <= state_next;
    end

    assign pinSync = state_reg.stage2;

endmodule : pin_sync

// >>> hdl/word_fifo.sv
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [PW:0]                 count;
    } fifo_state_t;

    fifo_state_t state_reg;
    fifo_state_t state_next;
    logic        doPush;
    logic        doPop;

    always_comb
    begin
        state_next = state_reg;
        doPush     = inValid && (state_reg.count != (PW+1)'(DEPTH));
        doPop      = state_reg.count != '0 && outReady;
        if (doPush)
        begin
            state_next.mem[state_reg.wrPtr] = inData;
            state_next.wrPtr = (state_reg.wrPtr == PW'(DEPTH - 1)) ? '0 : state_reg.wrPtr + 1'b1;
        end
        if (doPop)
            state_next.rdPtr = (state_reg.rdPtr == PW'(DEPTH - 1)) ? '0 : state_reg.rdPtr + 1'b1;
        if (doPush && !doPop)
            state_next.count = state_reg.count + 1'b1;
        else if (doPop && !doPush)
            state_next.count = state_reg.count - 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign inReady  = state_reg.count != (PW+1)'(DEPTH);
    assign outValid = state_reg.count != '0;
    assign outData  = state_reg.mem[state_reg.rdPtr];

endmodule : word_fifo

// >>> hdl/parallel_prog_command_port.sv
`timescale 1ns/1ps

// Function
// - Strobe with action 00 loads address low or high byte per first select.
// - Strobe with action 01 loads data low or high byte per first select.
// - Strobe with action 10 loads the data bus into the command register.
// - Action 11 is idle; registers change only on a load strobe.
// - Write or output-enable pulse performs the action of the held command.
// - Decode 80h chip erase, 40h write fuses, 20h write lock bits.
// - Decode 10h write flash, 11h write EEPROM.
// - Decode 08h read signature/calibration, 04h read fuse and lock bits.
// - Decode 02h read flash, 03h read EEPROM.
// - Drive data bus only while output enable is low.
// - Ready/busy low during an operation, high when ready.
// - Command and address stay loaded across operations.
// - Erase clears flash, EEPROM, locks; keeps fuses; keep-EEPROM fuse honoured.
// - Write pulse under erase starts erase, busy low until done.
// - Flash data collects in a page buffer, page programmed at once.
// - First lock bit blocks writes and fuses; both also block verify reads.
// - Write pulse under write flash programs the buffered page, busy meanwhile.
module parallel_prog_command_port (
    input  wire logic                                   clk,
    input  wire logic                                   sys_rst,
    input  wire logic                                   loadStrobe,
    input  wire logic                                   loadActionLo,
    input  wire logic                                   loadActionHi,
    input  wire logic                                   byteSelectFirst,
    input  wire logic                                   writeN,
    input  wire logic                                   outputEnableN,
    input  wire logic [7:0]                             dataIn,
    output logic      [7:0]                             dataOut,
    output logic                                        dataOe,
    output logic                                        readyBusyN,
    input  wire logic [1:0]                             lockBits,
    input  wire logic                                   keepEepromOnEraseN,
    output prog_port_pkg::op_kind_t                     opKind,
    output logic                                        opStart,
    output logic      [15:0]                            opAddr,
    output logic      [15:0]                            opData,
    output logic                                        opHighSel,
    output logic                                        eraseKeepsEeprom,
    input  wire logic                                   opDone,
    output logic                                        pageWordValid,
    input  wire logic                                   pageWordReady,
    output logic      [prog_port_pkg::WORD_FIFO_WIDTH-1:0] pageWordData,
    output prog_port_pkg::read_kind_t                   readKind,
    output logic      [15:0]                            readAddr,
    output logic      [1:0]                             readSel,
    input  wire logic [7:0]                             readData
);
    import prog_port_pkg::*;

    typedef struct packed {
        logic                             strobePrev;
        logic                             writePrev;
        logic [7:0]                       command;
        logic [7:0]                       addrLo;
        logic [7:0]                       addrHi;
        logic [7:0]                       dataLo;
        logic [7:0]                       dataHi;
        logic                             opActive;
        logic                             opStart;
        op_kind_t                         opKind;
        logic [15:0]                      opAddr;
        logic [15:0]                      opData;
        logic                             opHighSel;
        logic                             keepEeprom;
        logic                             pushValid;
        logic [WORD_FIFO_WIDTH-1:0]       pushData;
        logic                             readyBusyN;
        logic [7:0]                       dataOut;
        logic                             dataOe;
        read_kind_t                       readKind;
        logic [15:0]                      readAddr;
        logic [1:0]                       readSel;
    } port_state_t;

    port_state_t state_reg;
    port_state_t state_next;

    logic       strobeSync;
    logic       writeNSync;
    logic       oeNSync;
    logic [1:0] actionSync;
    logic       bsFirstSync;
    logic [7:0] dataSync;
    logic       fifoInReady;
    logic       strobeRise;
    logic       writeFall;
    logic       busy;
    logic       writeLocked;
    logic       readLocked;
    op_kind_t   cmdOp;
    read_kind_t cmdRead;

    // Every pin except lockBits, keepEepromOnEraseN and the backend inputs opDone, pageWordReady, readData crosses two flops before use
    pin_sync #(
        .WIDTH      (14),
        .RESET_VALUE(14'h3800)
    ) u_pin_sync (
        .clk    (clk),
        .sys_rst(sys_rst),
        .pinIn  ({writeN, outputEnableN, loadActionHi, loadStrobe, loadActionLo,
                  byteSelectFirst, dataIn}),
        .pinSync({writeNSync, oeNSync, actionSync[1], strobeSync, actionSync[0],
                  bsFirstSync, dataSync})
    );

    // Page words wait here until the array backend drains them
    word_fifo #(
        .WIDTH(WORD_FIFO_WIDTH),
        .DEPTH(WORD_FIFO_DEPTH)
    ) u_word_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .inValid (state_reg.pushValid),
        .inReady (fifoInReady),
        .inData  (state_reg.pushData),
        .outValid(pageWordValid),
        .outReady(pageWordReady),
        .outData (pageWordData)
    );

    // Command decode
    always_comb
    begin
        case (state_reg.command)
            CMD_CHIP_ERASE:  cmdOp = OP_CHIP_ERASE;
            CMD_WRITE_FUSE:  cmdOp = OP_WRITE_FUSE;
            CMD_WRITE_LOCK:  cmdOp = OP_WRITE_LOCK;
            CMD_WRITE_FLASH: cmdOp = OP_WRITE_FLASH;
            CMD_WRITE_EEP:   cmdOp = OP_WRITE_EEP;
            default:         cmdOp = OP_NONE;
        endcase
        case (state_reg.command)
            CMD_READ_SIG:    cmdRead = RD_SIG;
            CMD_READ_FUSE:   cmdRead = RD_FUSE;
            CMD_READ_FLASH:  cmdRead = RD_FLASH;
            CMD_READ_EEP:    cmdRead = RD_EEP;
            default:         cmdRead = RD_NONE;
        endcase
    end

    assign strobeRise  = strobeSync && !state_reg.strobePrev;
    assign writeFall   = !writeNSync && state_reg.writePrev;
    assign busy        = state_reg.opActive || state_reg.pushValid || !fifoInReady;
    assign writeLocked = !lockBits[LOCK_BIT1_POS];
    assign readLocked  = !lockBits[LOCK_BIT1_POS] && !lockBits[LOCK_BIT2_POS];

    always_comb
    begin
        state_next            = state_reg;
        state_next.strobePrev = strobeSync;
        state_next.writePrev  = writeNSync;
        state_next.opStart    = 1'b0;
        if (state_reg.pushValid && fifoInReady)
            state_next.pushValid = 1'b0;

        // Loads; other states keep their contents
        if (strobeRise && !busy)
        begin
            case (actionSync)
                ACT_ADDR:
                begin
                    if (bsFirstSync)
                        state_next.addrHi = dataSync;
                    else
                        state_next.addrLo = dataSync;
                end
                ACT_DATA:
                begin
                    if (bsFirstSync)
                        state_next.dataHi = dataSync;
                    else
                        state_next.dataLo = dataSync;
                    // Completed words enter the page buffer
                    if ((cmdOp == OP_WRITE_FLASH && bsFirstSync)
                        || (cmdOp == OP_WRITE_EEP && !bsFirstSync))
                    begin
                        state_next.pushValid = 1'b1;
                        state_next.pushData  = bsFirstSync
                            ? {state_reg.addrLo, dataSync, state_reg.dataLo}
                            : {state_reg.addrLo, 8'h00, dataSync};
                    end
                end
                ACT_CMD:  state_next.command = dataSync;
                ACT_IDLE: state_next.command = state_reg.command;
                default:  state_next.command = state_reg.command;
            endcase
        end

        // Write pulse starts the held command's operation
        if (writeFall && !busy && cmdOp != OP_NONE)
        begin
            if (cmdOp == OP_CHIP_ERASE || !writeLocked)
            begin
                state_next.opActive   = 1'b1;
                state_next.opStart    = 1'b1;
                state_next.opKind     = cmdOp;
                state_next.opAddr     = {state_reg.addrHi, state_reg.addrLo};
                state_next.opData     = {state_reg.dataHi, state_reg.dataLo};
                state_next.opHighSel  = bsFirstSync;
                state_next.keepEeprom = !keepEepromOnEraseN;
            end
        end
        else if (state_reg.opActive && !state_reg.opStart && opDone)
        begin
            state_next.opActive = 1'b0;
        end

        state_next.readyBusyN = !(state_next.opActive || state_next.pushValid
                                  || !fifoInReady);

        // Reads while output enable is low
        state_next.readKind = cmdRead;
        state_next.readAddr = {state_reg.addrHi, state_reg.addrLo};
        state_next.readSel  = {actionSync[1], bsFirstSync};
        state_next.dataOe   = !oeNSync && cmdRead != RD_NONE;
        if ((cmdRead == RD_FLASH || cmdRead == RD_EEP) && readLocked)
            state_next.dataOut = REFUSED_READ_BYTE;
        else
            state_next.dataOut = readData;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg            <= '0;
            state_reg.writePrev  <= 1'b1;
            state_reg.readyBusyN <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign dataOut          = state_reg.dataOut;
    assign dataOe           = state_reg.dataOe;
    assign readyBusyN       = state_reg.readyBusyN;
    assign opKind           = state_reg.opKind;
    assign opStart          = state_reg.opStart;
    assign opAddr           = state_reg.opAddr;
    assign opData           = state_reg.opData;
    assign opHighSel        = state_reg.opHighSel;
    assign eraseKeepsEeprom = state_reg.keepEeprom;
    assign readKind         = state_reg.readKind;
    assign readAddr         = state_reg.readAddr;
    assign readSel          = state_reg.readSel;

endmodule : parallel_prog_command_port

// >>> tb/parallel_prog_command_port_properties.sv
`timescale 1ns/1ps

module parallel_prog_command_port_properties
    import prog_port_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       writeN,
    input wire logic                       outputEnableN,
    input wire logic [7:0]                 dataOut,
    input wire logic                       dataOe,
    input wire logic                       readyBusyN,
    input wire logic [1:0]                 lockBits,
    input wire logic                       keepEepromOnEraseN,
    input wire logic                       eraseKeepsEeprom,
    input wire op_kind_t                   opKind,
    input wire logic                       opStart,
    input wire logic                       opDone,
    input wire logic                       pageWordValid,
    input wire logic                       pageWordReady,
    input wire logic [WORD_FIFO_WIDTH-1:0] pageWordData,
    input wire read_kind_t                 readKind,
    input wire logic [7:0]                 readData
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence op_begin;
        opStart;
    endsequence

    sequence no_done2;
        !opDone ##1 !opDone;
    endsequence

    oe_drive_a: assert property (outputEnableN [*4] |-> !dataOe)
        else $error("data bus driven with output enable high");
    start_busy_a: assert property (op_begin |-> !readyBusyN)
        else $error("operation started while ready shown");
    start_cause_a: assert property (op_begin |-> !$past(writeN))
        else $error("operation started without write pulse");
    lock_refuse_a: assert property (
        op_begin |-> (opKind == OP_CHIP_ERASE || $past(lockBits[0])))
        else $error("write started under lock");
    erase_keep_a: assert property (
        opStart && opKind == OP_CHIP_ERASE |-> eraseKeepsEeprom == !$past(keepEepromOnEraseN))
        else $error("keep eeprom flag wrong at erase");
    busy_hold_a: assert property (op_begin ##1 no_done2 |-> !readyBusyN)
        else $error("ready before operation done");
    busy_release_a: assert property (opDone && !opStart && !readyBusyN |=> readyBusyN)
        else $error("ready not restored after done");
    read_data_a: assert property (dataOe && $past(dataOe) && $past(readKind) != RD_NONE
        |-> dataOut == ((($past(readKind) inside {RD_FLASH, RD_EEP}) && $past(lockBits) == 2'b00)
        ? REFUSED_READ_BYTE : $past(readData)))
        else $error("read byte on bus wrong");
    word_hold_a: assert property (pageWordValid && !pageWordReady |=> pageWordValid && $stable(pageWordData))
        else $error("page word dropped while stalled");
endmodule : parallel_prog_command_port_properties

bind parallel_prog_command_port parallel_prog_command_port_properties i_props (
    .clk(clk), .sys_rst(sys_rst), .writeN(writeN), .outputEnableN(outputEnableN),
    .dataOut(dataOut), .dataOe(dataOe), .readyBusyN(readyBusyN), .lockBits(lockBits),
    .keepEepromOnEraseN(keepEepromOnEraseN), .eraseKeepsEeprom(eraseKeepsEeprom),
    .opKind(opKind), .opStart(opStart), .opDone(opDone), .pageWordValid(pageWordValid),
    .pageWordReady(pageWordReady), .pageWordData(pageWordData), .readKind(readKind),
    .readData(readData)
);

// >>> tb/prog_backend_model.sv
`timescale 1ns/1ps

module prog_backend_model
    import prog_port_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        opStart,
    output logic             opDone,
    input  wire logic        pageWordValid,
    output logic             pageWordReady,
    input  wire logic        drainStall,
    input  wire logic [7:0]  doneDelay,
    input  wire read_kind_t  readKind,
    input  wire logic [15:0] readAddr,
    input  wire logic [1:0]  readSel,
    output logic [7:0]       readData
);
    logic       running;
    logic [7:0] waitCnt;

    assign pageWordReady = !drainStall;
    // Memory contents as a pure function of kind, address and select
    assign readData = readAddr[7:0] ^ readAddr[15:8] ^ {readSel, 3'h0, readKind};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            running <= 1'b0;
            waitCnt <= 8'h00;
            opDone  <= 1'b0;
        end
        else
        begin
            opDone <= 1'b0;
            if (opStart)
            begin
                running <= 1'b1;
                waitCnt <= doneDelay;
            end
            else if (running && waitCnt != 8'h00)
                waitCnt <= waitCnt - 8'h01;
            else if (running && !pageWordValid)
            begin
                running <= 1'b0;
                opDone  <= 1'b1;
            end
        end
    end
endmodule : prog_backend_model

// >>> tb/tb_parallel_prog_command_port.sv
`timescale 1ns/1ps

module tb_parallel_prog_command_port;
    import prog_port_pkg::*;

    localparam int         PW = 63;
    localparam logic [7:0] RC[4] = '{CMD_READ_SIG, CMD_READ_FUSE, CMD_READ_FLASH, CMD_READ_EEP};
    localparam read_kind_t RK[4] = '{RD_SIG, RD_FUSE, RD_FLASH, RD_EEP};
    localparam logic [7:0] WC[5] = '{CMD_WRITE_FUSE, CMD_WRITE_LOCK, CMD_WRITE_EEP,
                                     CMD_WRITE_FLASH, CMD_CHIP_ERASE};
    localparam op_kind_t   WK[5] = '{OP_WRITE_FUSE, OP_WRITE_LOCK, OP_WRITE_EEP,
                                     OP_WRITE_FLASH, OP_CHIP_ERASE};
    logic        clk = 1'b0, sys_rst = 1'b1, loadStrobe = 1'b0, drainStall = 1'b0;
    logic        loadActionLo = 1'b0, loadActionHi = 1'b0, byteSelectFirst = 1'b0;
    logic        writeN = 1'b0, outputEnableN = 1'b1, keepEepromOnEraseN = 1'b1;
    logic [7:0]  dataIn = 8'h00, doneDelay = 8'd30, dataOut, readData;
    logic [1:0]  lockBits = 2'b11, readSel;
    logic        dataOe, readyBusyN, opStart, opHighSel, eraseKeepsEeprom, opDone;
    logic        pageWordValid, pageWordReady;
    logic [15:0] opAddr, opData, readAddr;
    logic [23:0] pageWordData, gotQ[$], expQ[$];
    op_kind_t    opKind, lastKind;
    read_kind_t  readKind;
    int          nErrors = 0, testsRun = 0, startCnt = 0;

    always #2 clk = ~clk;

    parallel_prog_command_port i_dut (
        .clk(clk), .sys_rst(sys_rst), .loadStrobe(loadStrobe), .loadActionLo(loadActionLo),
        .loadActionHi(loadActionHi), .byteSelectFirst(byteSelectFirst), .writeN(writeN),
        .outputEnableN(outputEnableN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .readyBusyN(readyBusyN), .lockBits(lockBits), .keepEepromOnEraseN(keepEepromOnEraseN),
        .opKind(opKind), .opStart(opStart), .opAddr(opAddr), .opData(opData),
        .opHighSel(opHighSel), .eraseKeepsEeprom(eraseKeepsEeprom), .opDone(opDone),
        .pageWordValid(pageWordValid), .pageWordReady(pageWordReady),
        .pageWordData(pageWordData), .readKind(readKind), .readAddr(readAddr),
        .readSel(readSel), .readData(readData)
    );

    prog_backend_model i_backend (
        .clk(clk), .sys_rst(sys_rst), .opStart(opStart), .opDone(opDone),
        .pageWordValid(pageWordValid), .pageWordReady(pageWordReady),
        .drainStall(drainStall), .doneDelay(doneDelay), .readKind(readKind),
        .readAddr(readAddr), .readSel(readSel), .readData(readData)
    );

    always @(posedge clk)
    begin
        if (opStart === 1'b1)
        begin
            startCnt++;
            lastKind = opKind;
        end
        if (pageWordValid === 1'b1 && pageWordReady === 1'b1)
            gotQ.push_back(pageWordData);
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_word({16'h0, got}, {16'h0, exp});
    endtask : chk_byte

    task automatic finish_test();
        $display("errors %0d comparisons %0d", nErrors, testsRun);
        if (nErrors == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    function automatic logic [7:0] exp_rd(read_kind_t k, logic [1:0] s, logic [15:0] a);
        if ((k == RD_FLASH || k == RD_EEP) && lockBits == 2'b00)
            return REFUSED_READ_BYTE;
        return a[7:0] ^ a[15:8] ^ {s, 3'h0, k};
    endfunction : exp_rd

    task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] d);
        {loadActionHi, loadActionLo} = act;
        byteSelectFirst = sel;
        dataIn = d;
        cyc(4);
        loadStrobe = 1'b1;
        cyc(PW);
        loadStrobe = 1'b0;
        cyc(PW);
        {loadActionHi, loadActionLo} = ACT_IDLE;
    endtask : load

    task automatic wr(input logic bsy, input logic [7:0] mid);
        int i;
        writeN = 1'b0;
        cyc(8);
        chk_byte({7'h0, readyBusyN}, {7'h0, !bsy});
        cyc(PW - 8);
        writeN = 1'b1;
        cyc(8);
        if (mid != 8'h00)
            load(ACT_CMD, 1'b0, mid);
        for (i = 0; i < 3000 && readyBusyN !== 1'b1; i++)
            cyc(1);
        chk_byte({7'h0, readyBusyN}, 8'h01);
    endtask : wr

    task automatic rd(input read_kind_t k, input logic [1:0] s, input logic [15:0] a);
        loadActionHi = s[1];
        byteSelectFirst = s[0];
        outputEnableN = 1'b0;
        cyc(8);
        chk_byte({5'h0, readKind}, {5'h0, k});
        chk_byte({7'h0, dataOe}, {7'h0, k != RD_NONE});
        if (k != RD_NONE)
            chk_byte(dataOut, exp_rd(k, s, a));
        chk_word({6'h0, readSel, readAddr}, {6'h0, s, a});
        outputEnableN = 1'b1;
        cyc(8);
        chk_byte({7'h0, dataOe}, 8'h00);
        loadActionHi = 1'b1;
    endtask : rd

    initial
    begin
        logic [15:0] ad, w;
        logic [7:0]  lo;
        logic [1:0]  s;
        int          k, n0;
        void'($urandom(32'h5807f3a1));
        cyc(8);
        {writeN, loadActionHi, loadActionLo} = 3'b111;
        sys_rst = 1'b0;
        cyc(2);
        for (k = 0; k < 4; k++)
        begin
            ad = 16'($urandom);
            s = (k == 1) ? 2'($urandom) : {1'b0, 1'($urandom)};
            load(ACT_CMD, 1'b0, RC[k]);
            load(ACT_ADDR, 1'b1, ad[15:8]);
            load(ACT_ADDR, 1'b0, ad[7:0]);
            rd(RK[k], s, ad);
        end
        lockBits = 2'b00;
        rd(RD_EEP, 2'b00, ad);
        load(ACT_CMD, 1'b0, CMD_READ_SIG);
        rd(RD_SIG, 2'b00, ad);
        lockBits = 2'b11;
        load(ACT_IDLE, 1'b0, 8'h5a);
        rd(RD_SIG, 2'b01, ad);
        drainStall = 1'b1;
        load(ACT_CMD, 1'b0, CMD_WRITE_FLASH);
        for (k = 0; k < 5; k++)
        begin
            lo = (k == 0) ? 8'hff : 8'($urandom);
            w = 16'($urandom);
            load(ACT_ADDR, 1'b0, lo);
            load(ACT_DATA, 1'b0, w[7:0]);
            load(ACT_DATA, 1'b1, w[15:8]);
            if (k < 4)
                expQ.push_back({lo, w});
        end
        chk_byte({7'h0, readyBusyN}, 8'h00);
        drainStall = 1'b0;
        cyc(20);
        load(ACT_CMD, 1'b0, CMD_WRITE_EEP);
        load(ACT_ADDR, 1'b0, lo);
        load(ACT_DATA, 1'b0, w[7:0]);
        expQ.push_back({lo, 8'h00, w[7:0]});
        chk_word(24'(gotQ.size()), 24'(expQ.size()));
        foreach (expQ[i])
            chk_word(gotQ[i], expQ[i]);
        for (k = 0; k < 5; k++)
        begin
            doneDelay = 8'($urandom_range(20, 60));
            load(ACT_CMD, 1'b0, WC[k]);
            repeat (2)
            begin
                n0 = startCnt;
                wr(1'b1, 8'h00);
                chk_byte(8'(startCnt - n0), 8'h01);
                chk_byte({5'h0, lastKind}, {5'h0, WK[k]});
            end
        end
        doneDelay = 8'd200;
        keepEepromOnEraseN = 1'b0;
        load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
        wr(1'b1, CMD_READ_SIG);
        chk_byte({7'h0, eraseKeepsEeprom}, 8'h01);
        rd(RD_NONE, 2'b00, {ad[15:8], lo});
        doneDelay = 8'd30;
        lockBits = 2'b10;
        load(ACT_CMD, 1'b0, CMD_WRITE_FUSE);
        n0 = startCnt;
        wr(1'b0, 8'h00);
        chk_byte(8'(startCnt - n0), 8'h00);
        load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
        wr(1'b1, 8'h00);
        chk_byte({5'h0, lastKind}, {5'h0, OP_CHIP_ERASE});
        sys_rst = 1'b1;
        cyc(8);
        sys_rst = 1'b0;
        cyc(2);
        chk_byte({7'h0, readyBusyN}, 8'h01);
        rd(RD_NONE, 2'b00, 16'h0000);
        finish_test();
    end

    initial
    begin
        #200000;
        nErrors++;
        finish_test();
    end
endmodule : tb_parallel_prog_command_port
